// >>> rtl/cbi_cpu_ctl.sv
// Bus-cycle, stall, interrupt and reset control of an 8-bit processor
`timescale 1ns/100ps
`include "cbi_map.svh"

// Notes on behaviour
// RULE1 - Phases come from external two-phase pins or an internal divider.
// RULE2 - Data drivers on only while the data output gate is high.
// RULE3 - Data drivers always off in read cycles.
// RULE4 - Ready low in a read cycle halts with the address held.
// RULE5 - Halt lasts while ready stays low through phase two.
// RULE6 - Ready low in a write cycle is ignored until the next read.
// RULE7 - Outside party keeps ready stable throughout phase two.
// RULE8 - Maskable request taken after the instruction, only if mask clear.
// RULE9 - Interrupt entry pushes counter high, low, then status.
// RULE10 - Mask flag set after stacking.
// RULE11 - Maskable vector low byte FFFE, high byte FFFF.
// RULE12 - Interrupt requests recognised only while ready is high; the non-maskable request ignores ready.
// RULE13 - Falling non-maskable input forces entry via FFFA and FFFB.
// RULE14 - Interrupt inputs sampled in phase two; entry starts next phase one.
// RULE15 - Falling set-overflow input, sampled at phase one end, sets overflow.
// RULE16 - Fetch marker high for the whole opcode fetch cycle.
// RULE17 - Ready low while marker is high stops the core: single stepping.
// RULE18 - No writes while reset is held low.
// RULE19 - After reset, six cycles, then mask set and vector FFFC/FFFD.
// RULE20 - Outside party holds reset low two cycles after power-up.
// RULE21 - Direction high for transfers in, low for transfers out.
// RULE22 - Absolute operand low byte then high; immediate uses byte two.
module cbi_cpu_ctl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_phase_sel,
  input wire logic ph1_in,
  input wire logic ph2_in,
  output logic ph1_out,
  output logic ph2_out,
  input wire logic data_output_gate,
  input wire logic rdy,
  input wire logic irq_n,
  input wire logic nmi_n,
  input wire logic so_n,
  output logic [15:0] address_bus_lines,
  input wire logic [7:0] data_bus_lines_in,
  output logic [7:0] data_bus_lines_out,
  output logic data_bus_lines_oe_n,
  output logic rw,
  output logic sync
);
  import cbi_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  cbi_core_s q;
  cbi_core_s d;
  cbi_core_s rst_val;
  logic [1:0] rst_q;
  logic rst_s_n;
  logic ph1_end;
  logic ph2_end;
  logic [7:0] db_s;
  logic rdy_s;
  logic irq_s;
  logic nmi_s;
  logic so_s;
  logic gate_s;
  logic stall;
  logic fin;

  function automatic logic is_store(input logic [7:0] op);
    is_store = (op == `CBI_OP_STA_ABS);
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q <= 2'b00;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_s_n = rst_q[1];

  // ****************************************
  // Phase source
  // ****************************************
  // RULE1 phase clock choice
  cbi_phase u_phase (
    .clk(clk),
    .rst_sync_n(rst_s_n),
    .ext_phase_sel(ext_phase_sel),
    .ph1_in(ph1_in),
    .ph2_in(ph2_in),
    .ph1_out(ph1_out),
    .ph2_out(ph2_out),
    .ph1_end(ph1_end),
    .ph2_end(ph2_end)
  );

  // ****************************************
  // Synchronised pins
  // ****************************************
  assign db_s = q.sy_b[7:0];
  assign rdy_s = q.sy_b[8];
  assign irq_s = q.sy_b[9];
  assign nmi_s = q.sy_b[10];
  assign so_s = q.sy_b[11];
  assign gate_s = q.sy_b[12];

  // RULE4 halt on read
  // RULE6 writes ignore ready
  // RULE17 stop at fetch
  assign stall = q.rw && !rdy_s;

  // ****************************************
  // Bus outputs
  // ****************************************
  assign address_bus_lines = q.addr;
  assign data_bus_lines_out = q.dout;
  assign rw = q.rw;
  assign sync = q.sync;
  // RULE2 gate enables drive
  // RULE3 reads never drive
  assign data_bus_lines_oe_n = !(gate_s && !q.rw);

  // ****************************************
  // Reset value
  // ****************************************
  always_comb
  begin
    rst_val = '0;
    rst_val.state = st_rst;
    rst_val.sp = `CBI_SP_RST;
    rst_val.p = `CBI_P_RST;
    rst_val.rw = 1'b1;
    rst_val.nmi_prev = 1'b1;
    rst_val.so_prev = 1'b1;
    rst_val.sy_a = `CBI_SYNC_RST;
    rst_val.sy_b = `CBI_SYNC_RST;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    fin = 1'b0;
    d.sy_a = {data_output_gate, so_n, nmi_n, irq_n, rdy, data_bus_lines_in};
    d.sy_b = q.sy_a;
    if (ph1_end)
    begin
      d.so_prev = so_s;
      // RULE15 overflow edge
      if (q.so_prev && !so_s)
      begin
        d.p[`CBI_P_V] = 1'b1;
      end
    end
    // RULE5 hold while ready low
    if (ph2_end && !stall)
    begin
      unique case (q.state)
        st_rst:
        begin
          // RULE19 six cycle start
          if (q.rcnt == `CBI_RST_CYC - 3'd1)
          begin
            d.p[`CBI_P_I] = 1'b1;
            d.vec = `CBI_VEC_RST;
            d.state = st_vlo;
          end
          else
          begin
            d.rcnt = q.rcnt + 3'd1;
          end
        end
        st_vlo:
        begin
          d.pc[7:0] = db_s;
          d.state = st_vhi;
        end
        st_vhi:
        begin
          d.pc[15:8] = db_s;
          d.state = st_fetch;
        end
        st_fetch:
        begin
          d.ir = db_s;
          d.pc = q.pc + 16'h0001;
          d.state = st_op1;
          if (db_s == `CBI_OP_CLI)
          begin
            d.p[`CBI_P_I] = 1'b0;
            fin = 1'b1;
          end
          else if (db_s == `CBI_OP_SEI)
          begin
            d.p[`CBI_P_I] = 1'b1;
            fin = 1'b1;
          end
          else if (db_s == `CBI_OP_CLV)
          begin
            d.p[`CBI_P_V] = 1'b0;
            fin = 1'b1;
          end
          else if (db_s == `CBI_OP_ASL_A)
          begin
            d.a = {q.a[6:0], 1'b0};
            fin = 1'b1;
          end
          else if (db_s != `CBI_OP_LDA_IMM && db_s != `CBI_OP_LDA_ABS
                   && db_s != `CBI_OP_JMP_ABS && !is_store(db_s))
          begin
            fin = 1'b1;
          end
        end
        st_op1:
        begin
          d.opl = db_s;
          d.pc = q.pc + 16'h0001;
          // RULE22 immediate operand
          if (q.ir == `CBI_OP_LDA_IMM)
          begin
            d.a = db_s;
            fin = 1'b1;
          end
          else
          begin
            d.state = st_op2;
          end
        end
        st_op2:
        begin
          // RULE22 low then high
          d.ea = {db_s, q.opl};
          d.pc = q.pc + 16'h0001;
          if (q.ir == `CBI_OP_JMP_ABS)
          begin
            d.pc = {db_s, q.opl};
            fin = 1'b1;
          end
          else
          begin
            d.state = st_mem;
          end
        end
        st_mem:
        begin
          if (!is_store(q.ir))
          begin
            d.a = db_s;
          end
          fin = 1'b1;
        end
        st_psh_h:
        begin
          d.sp = q.sp - 8'h01;
          d.state = st_psh_l;
        end
        st_psh_l:
        begin
          d.sp = q.sp - 8'h01;
          d.state = st_psh_p;
        end
        st_psh_p:
        begin
          d.sp = q.sp - 8'h01;
          // RULE10 mask after stacking
          d.p[`CBI_P_I] = 1'b1;
          d.state = st_vlo;
        end
      endcase
      if (fin)
      begin
        // RULE13 unconditional entry
        if (q.nmi_pend)
        begin
          d.nmi_pend = 1'b0;
          d.vec = `CBI_VEC_NMI;
          d.state = st_psh_h;
        end
        // RULE8 mask checked
        // RULE12 ready high only
        else if (!irq_s && rdy_s && !d.p[`CBI_P_I])
        begin
          // RULE11 maskable vector
          d.vec = `CBI_VEC_IRQ;
          d.state = st_psh_h;
        end
        else
        begin
          d.state = st_fetch;
        end
      end
      // RULE14 next cycle bus
      d.rw = 1'b1;
      d.dout = q.dout;
      unique case (d.state)
        st_rst:
        begin
          d.addr = d.pc;
        end
        st_vlo:
        begin
          d.addr = d.vec;
        end
        st_vhi:
        begin
          d.addr = d.vec | 16'h0001;
        end
        st_fetch, st_op1, st_op2:
        begin
          d.addr = d.pc;
        end
        st_mem:
        begin
          d.addr = d.ea;
          // RULE21 direction
          d.rw = !is_store(d.ir);
          d.dout = d.a;
        end
        st_psh_h:
        begin
          // RULE9 stack pushes
          d.addr = {`CBI_STACK_PAGE, d.sp};
          d.rw = 1'b0;
          d.dout = d.pc[15:8];
        end
        st_psh_l:
        begin
          d.addr = {`CBI_STACK_PAGE, d.sp};
          d.rw = 1'b0;
          d.dout = d.pc[7:0];
        end
        st_psh_p:
        begin
          d.addr = {`CBI_STACK_PAGE, d.sp};
          d.rw = 1'b0;
          d.dout = d.p;
        end
      endcase
      // RULE16 fetch marker
      d.sync = (d.state == st_fetch);
    end
    if (ph2_end)
    begin
      d.nmi_prev = nmi_s;
      // RULE13 edge latch, set wins
      if (q.nmi_prev && !nmi_s)
      begin
        d.nmi_pend = 1'b1;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // RULE18 reset holds reads
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      q <= '{state: st_rst, sp: `CBI_SP_RST, p: `CBI_P_RST, rw: 1'b1,
             nmi_prev: 1'b1, so_prev: 1'b1, sy_a: `CBI_SYNC_RST,
             sy_b: `CBI_SYNC_RST, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_s_n);

  property p_gate;
    !data_bus_lines_oe_n |-> gate_s && !rw;
  endproperty
  a_gate: assert property (p_gate) else $error("drive without gate"); // RULE2

  property p_read_off;
    rw |-> data_bus_lines_oe_n;
  endproperty
  a_read_off: assert property (p_read_off) else $error("drive in read"); // RULE3

  property p_halt;
    (ph2_end && rw && !rdy_s) |=> $stable(q.state) && $stable(address_bus_lines);
  endproperty
  a_halt: assert property (p_halt) else $error("no halt on ready low"); // RULE4

  property p_write_go;
    (ph2_end && !rw) |=> (q.state != $past(q.state));
  endproperty
  a_write_go: assert property (p_write_go) else $error("write stalled"); // RULE6

  property p_mask;
    (ph2_end && rdy_s && q.state == st_psh_p) |=> q.p[`CBI_P_I] && q.state == st_vlo;
  endproperty
  a_mask: assert property (p_mask) else $error("mask not set"); // RULE10

  property p_vec;
    q.state == st_vhi |-> address_bus_lines == (q.vec | 16'h0001) && rw;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector address"); // RULE11

  property p_nmi;
    (ph2_end && q.nmi_prev && !nmi_s) |=> q.nmi_pend;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi edge lost"); // RULE13

  property p_so;
    (ph1_end && q.so_prev && !so_s) |=> q.p[`CBI_P_V];
  endproperty
  a_so: assert property (p_so) else $error("overflow not set"); // RULE15

  property p_sync;
    sync == (q.state == st_fetch);
  endproperty
  a_sync: assert property (p_sync) else $error("fetch marker wrong"); // RULE16

  property p_rst_vec;
    (ph2_end && rdy_s && q.state == st_rst && q.rcnt == 3'd5)
      |=> address_bus_lines == `CBI_VEC_RST && q.p[`CBI_P_I];
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector wrong"); // RULE19

  property p_dir;
    !rw |-> q.state inside {st_mem, st_psh_h, st_psh_l, st_psh_p};
  endproperty
  a_dir: assert property (p_dir) else $error("write outside write state"); // RULE21

  c_irq: cover property (q.state == st_psh_h && q.vec == `CBI_VEC_IRQ);
  c_nmi: cover property (q.state == st_psh_h && q.vec == `CBI_VEC_NMI);
  c_halt: cover property (ph2_end && sync && !rdy_s);
  c_store: cover property (!data_bus_lines_oe_n);

endmodule

// >>> rtl/cbi_map.svh
// Constants of the bus, interrupt and reset control block
`ifndef CBI_MAP_SVH
`define CBI_MAP_SVH

// ****************************************
// Timing
// ****************************************
`define CBI_CLK_NS 10
`define CBI_PHASE_NS 500
`define CBI_PHASE_CYC ((`CBI_PHASE_NS + `CBI_CLK_NS - 1) / `CBI_CLK_NS)
`define CBI_RST_CYC 3'd6

// ****************************************
// Vectors and stack
// ****************************************
`define CBI_VEC_NMI 16'hfffa
`define CBI_VEC_RST 16'hfffc
`define CBI_VEC_IRQ 16'hfffe
`define CBI_STACK_PAGE 8'h01
`define CBI_SP_RST 8'hff

// ****************************************
// Status register
// ****************************************
`define CBI_P_RST 8'h20
`define CBI_P_V 6
`define CBI_P_I 2

// ****************************************
// Opcodes kept by the core
// ****************************************
`define CBI_OP_LDA_IMM 8'ha9
`define CBI_OP_LDA_ABS 8'had
`define CBI_OP_STA_ABS 8'h8d
`define CBI_OP_JMP_ABS 8'h4c
`define CBI_OP_ASL_A 8'h0a
`define CBI_OP_CLI 8'h58
`define CBI_OP_SEI 8'h78
`define CBI_OP_CLV 8'hb8

// ****************************************
// Input synchroniser reset, interrupt and overflow inputs set
// ****************************************
`define CBI_SYNC_RST 13'h0e00

`endif

// >>> rtl/cbi_pkg.sv
// Types of the bus, interrupt and reset control block
package cbi_pkg;

  typedef enum logic [9:0]
  {
    st_rst = 10'h001,
    st_vlo = 10'h002,
    st_vhi = 10'h004,
    st_fetch = 10'h008,
    st_op1 = 10'h010,
    st_op2 = 10'h020,
    st_mem = 10'h040,
    st_psh_h = 10'h080,
    st_psh_l = 10'h100,
    st_psh_p = 10'h200
  } cbi_state_e;

  typedef struct packed
  {
    cbi_state_e state;
    logic [15:0] pc;
    logic [15:0] ea;
    logic [15:0] vec;
    logic [15:0] addr;
    logic [7:0] ir;
    logic [7:0] opl;
    logic [7:0] a;
    logic [7:0] sp;
    logic [7:0] p;
    logic [7:0] dout;
    logic rw;
    logic sync;
    logic [2:0] rcnt;
    logic nmi_pend;
    logic nmi_prev;
    logic so_prev;
    logic [12:0] sy_a;
    logic [12:0] sy_b;
  } cbi_core_s;

  typedef struct packed
  {
    logic [7:0] cnt;
    logic ph;
    logic [2:0] s_a;
    logic [2:0] s_b;
    logic p1_prev;
    logic p2_prev;
  } cbi_phase_s;

endpackage

// >>> rtl/cbi_phase.sv
// Two-phase clock source as enables, internal divider or external pins
`timescale 1ns/100ps
module cbi_phase (
  input wire logic clk,
  input wire logic rst_sync_n,
  input wire logic ext_phase_sel,
  input wire logic ph1_in,
  input wire logic ph2_in,
  output logic ph1_out,
  output logic ph2_out,
  output logic ph1_end,
  output logic ph2_end
);
  import cbi_pkg::*;

  cbi_phase_s q;
  cbi_phase_s d;
  logic p1;
  logic p2;

  assign p1 = q.s_b[2] ? q.s_b[0] : !q.ph;
  assign p2 = q.s_b[2] ? q.s_b[1] : q.ph;
  assign ph1_out = p1;
  assign ph2_out = p2;
  assign ph1_end = q.p1_prev && !p1;
  assign ph2_end = q.p2_prev && !p2;

  // ****************************************
  // Divider and pin sampling
  // ****************************************
  always_comb
  begin
    d = q;
    d.s_a = {ext_phase_sel, ph2_in, ph1_in};
    d.s_b = q.s_a;
    d.p1_prev = p1;
    d.p2_prev = p2;
    if (q.cnt == 8'(`CBI_PHASE_CYC - 1))
    begin
      d.cnt = 8'h00;
      d.ph = !q.ph;
    end
    else
    begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule

// >>> sim/cbi_mem.sv
// Memory and peripheral model answering the processor's bus cycles
`timescale 1ns/100ps
module cbi_mem (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic rw,
  input wire logic oe_n,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] prog [0:15] = '{8'ha9, 8'h00, 8'h8d, 8'h34, 8'h12, 8'had, 8'h34, 8'h12,
    8'h0a, 8'h8d, 8'h35, 8'h12, 8'h58, 8'h4c, 8'h0d, 8'h02};
  logic [7:0] vec [0:5] = '{8'h00, 8'h04, 8'h00, 8'h02, 8'h00, 8'h03};
  logic [7:0] idle_q = 8'h5a;

  // ****************************************
  // Program image and vectors
  // ****************************************
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    foreach (prog[i])
      mem[16'h0200 + i] = prog[i];
    foreach (vec[i])
      mem[16'hfffa + i] = vec[i];
    for (int j = 3; j < 5; j++)
    begin
      mem[{j[7:0], 8'h00}] = 8'h4c;
      mem[{j[7:0], 8'h01}] = 8'h00;
      mem[{j[7:0], 8'h02}] = j[7:0];
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  // answer only reads
  assign rdata = rw ? mem[addr] : idle_q;

  always @(posedge clk)
  begin
    idle_q <= ~idle_q;
    if (!rw && !oe_n)
      mem[addr] <= wdata;
  end
endmodule

// >>> sim/testbench.sv
// Self-checking bench of the bus, interrupt and reset control block
`timescale 1ns/100ps
module testbench;
  import cbi_pkg::*;
  logic clk = 1'b0;
  logic rst_n, gate, rdy, irq_n, nmi_n, so_n, chk_rst;
  logic ph1, ph2, oe_n, rw, sync;
  logic [15:0] addr;
  logic [7:0] din, dout, r, m, c1, c2;
  logic [27:0] e;
  logic [31:0] seed;
  logic [31:0] rnd = 32'h51fa;
  logic ext_sel = 1'b0;
  logic p1i = 1'b0;
  logic p2i = 1'b0;
  int fail_count, tests_run, idx;
  logic [27:0] q [$];
  logic [27:0] tbl [0:40] = '{
    28'h1020100, 28'h3020200, 28'h1020300, 28'h1020400, 28'h0123400, 28'h3020500,
    28'h3020500, 28'h1020600, 28'h1020700, 28'h1123400, 28'h3020800, 28'h3020800,
    28'h3020800, 28'h3020900, 28'h1020a00, 28'h1020b00, 28'h0123500, 28'h3020c00,
    28'h3020d00, 28'h1020e00, 28'h1020f00, 28'h001ff02, 28'h001fe0d, 28'h401fd60,
    28'h1fffe00, 28'h1ffff00, 28'h3030000, 28'h1030100, 28'h1030200, 28'h3030000,
    28'h1030100, 28'h1030200, 28'h3030000, 28'h1030100, 28'h1030200, 28'h001fc03,
    28'h001fb00, 28'h401fa64, 28'h1fffa00, 28'h1fffb00, 28'h3040000};

  always #5 clk = ~clk;

  cbi_cpu_ctl u_dut (
    .clk(clk), .rst_n(rst_n), .ext_phase_sel(ext_sel), .ph1_in(p1i), .ph2_in(p2i),
    .ph1_out(ph1), .ph2_out(ph2), .data_output_gate(gate), .rdy(rdy), .irq_n(irq_n),
    .nmi_n(nmi_n), .so_n(so_n), .address_bus_lines(addr), .data_bus_lines_in(din),
    .data_bus_lines_out(dout), .data_bus_lines_oe_n(oe_n), .rw(rw), .sync(sync)
  );

  cbi_mem u_mem (
    .clk(clk), .addr(addr), .rw(rw), .oe_n(oe_n), .wdata(dout), .rdata(din)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test;
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  task automatic wait_to(input int n);
    int k;
    for (k = 0; k < 3000 && idx <= n; k++)
      @(posedge clk);
    if (idx <= n)
    begin
      fail_count++;
      $display("FAIL %0t timeout waiting for bus cycle", $time);
      finish_test;
    end
  endtask

  task automatic push_reset;
    repeat (6) q.push_back(28'h1000000);
    q.push_back(28'h1fffc00);
    q.push_back(28'h1fffd00);
    q.push_back(28'h3020000);
  endtask

  // ****************************************
  // Bus cycle monitor and comparison
  // ****************************************
  always @(posedge clk)
  begin
    gate <= ph2;
    // pins ignored while the divider runs
    rnd <= lfsr(rnd);
    p1i <= rnd[0];
    p2i <= rnd[1];
    c1 <= (ph1 && rst_n) ? c1 + 8'd1 : 8'd0;
    c2 <= (ph2 && rst_n) ? c2 + 8'd1 : 8'd0;
    if (!rst_n)
    begin
      idx <= 0;
      if (chk_rst)
        chk(rw === 1'b1, "write during reset");
    end
    else if (ph1 && c1 == 8'd25)
    begin
      idx <= idx + 1;
      if (q.size() == 0)
        chk(1'b0, "unexpected bus cycle");
      else
      begin
        e = q.pop_front();
        m = e[26] ? 8'h44 : 8'hff;
        chk(addr === e[23:8], "address");
        chk(rw === e[24], "direction");
        chk(sync === e[25], "fetch marker");
        chk(oe_n === 1'b1, "drivers on with gate low");
        if (!e[24])
          chk((dout & m) === (e[7:0] & m), "write data");
      end
    end
    else if (ph2 && c2 == 8'd25)
      chk(oe_n === rw, "drive enable in phase two");
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    gate = 1'b0;
    rdy = 1'b1;
    irq_n = 1'b1;
    nmi_n = 1'b1;
    so_n = 1'b1;
    chk_rst = 1'b0;
    c1 = 8'h00;
    c2 = 8'h00;
    fail_count = 0;
    tests_run = 0;
    idx = 0;
    seed = 32'h51fa;
    repeat (8) seed = lfsr(seed);
    r = seed[7:0];
    push_reset();
    foreach (tbl[i])
      q.push_back(tbl[i]);
    q[13][7:0] = r;
    q[25][7:0] = {r[6:0], 1'b0};
    @(posedge clk);
    u_mem.mem[16'h0201] = r;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_to(8);
    so_n <= 1'b0;
    wait_to(10);
    so_n <= 1'b1;
    wait_to(13);
    rdy <= 1'b0;
    wait_to(15);
    rdy <= 1'b1;
    wait_to(19);
    rdy <= 1'b0;
    wait_to(21);
    rdy <= 1'b1;
    wait_to(27);
    irq_n <= 1'b0;
    wait_to(41);
    irq_n <= 1'b1;
    nmi_n <= 1'b0;
    wait_to(49);
    nmi_n <= 1'b1;
    chk_rst <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    push_reset();
    rst_n <= 1'b1;
    chk_rst <= 1'b0;
    wait_to(8);
    chk(q.size() == 0, "bus cycles left over");
    finish_test;
  end
endmodule
